// File: dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module dev_model (
    input  wire logic        lclk_i,
    input  wire logic        rst_n_i,
    input  wire logic [31:0] bus_i,
    input  wire logic        hoe_i,
    input  wire logic        as_n_i,
    input  wire logic        cs_n_i,
    input  wire logic        rsel_i,
    input  wire logic        dir_i,
    input  wire logic        bl_n_i,
    input  wire logic [3:0]  ln_i,
    input  wire logic        gnt_i,
    input  wire logic [2:0]  wait_i,
    input  wire logic        want_i,
    output logic             rdy_n_o,
    output logic      [31:0] do_o,
    output logic             oe_o,
    output logic             hold_o,
    output logic      [31:0] cfg_o,
    output int               faults_o
);
    logic [31:0] win_q, ptr_q;
    logic        busy_q, wr_q, sel_q;
    int          cnt_q;
    initial begin
        rdy_n_o = 1;
        oe_o = 0;
        hold_o = 0;
        busy_q = 0;
        faults_o = 0;
    end
    always @(posedge lclk_i) begin
        if (!rst_n_i) begin
            cfg_o <= bus_i;
            faults_o += int'(hoe_i);
            busy_q <= 0;
        end else begin
            hold_o <= want_i;
            faults_o += int'(gnt_i && hoe_i);
            if (!cs_n_i && !as_n_i) begin
                faults_o += int'(bus_i[31:3] != 29'h0200_0000 || bus_i[2] != rsel_i);
                busy_q <= 1;
                wr_q <= dir_i;
                sel_q <= rsel_i;
                cnt_q <= wait_i + 1;
            end else if (busy_q && cnt_q > 0) begin
                cnt_q <= cnt_q - 1;
                rdy_n_o <= cnt_q != 1;
                oe_o <= cnt_q == 1 && !wr_q;
                do_o <= sel_q ? ptr_q : win_q;
            end else if (busy_q) begin
                faults_o += int'(bl_n_i !== 1'b0);
                busy_q <= 0;
                if (wr_q && sel_q)
                    ptr_q <= bus_i;
                for (int b = 0; b < 4; b++)
                    if (wr_q && !sel_q && ln_i[b])
                        win_q[8*b+:8] <= bus_i[8*b+:8];
            end else if (cs_n_i) begin
                // Ready stays low until select drops, so a late sample still sees it
                rdy_n_o <= 1;
                oe_o <= 0;
            end
        end
    end
endmodule // dev_model
`default_nettype wire

// File: host_glue.sv
// Operation
// - Shared 32-bit address/data path, no conversion
// - Address bit 2 drives register select
// - Decode chip select, qualified by address strobe
// - Address strobe marks the address cycle
// - Burst-last flags the final data beat
// - Four lane enables qualify byte lanes
// - Device reset first, bus not driven
// - Hold host off bus while device exits
// - Eight regions, each with width attribute
// - Device region programmed 32-bit wide
// - Load regions, then table-valid enables them
// - Data cache disabled by default
// - Byte order little-endian by default
`include "host_glue_params.svh"
`timescale 1ns/1ps
`default_nettype none

module host_glue
    import host_glue_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        shared_bus_clock_i,
    output logic             dev_reset_n_o,
    input  wire logic [31:0] shared_data_bus_i,
    output logic      [31:0] shared_data_bus_o,
    output logic             shared_data_bus_oe_o,
    output logic             host_addr_strobe_n_o,
    output logic             device_select_n_o,
    output logic             register_select_o,
    output logic             direction_o,
    output logic             host_burst_last_n_o,
    output logic      [3:0]  host_lane_enables_o,
    input  wire logic        host_ready_n_i,
    input  wire logic        bus_hold_request_i,
    output logic             bus_hold_grant_o,
    input  wire logic        interrupt_in_i,
    output logic             irq_o,
    input  wire logic        cmd_valid_i,
    output logic             cmd_ready_o,
    input  wire logic        cmd_write_i,
    input  wire logic        cmd_ptr_i,
    input  wire logic [31:0] cmd_wdata_i,
    input  wire logic [3:0]  cmd_lanes_i,
    output logic             wr_done_o,
    output logic             rsp_valid_o,
    output logic      [31:0] rsp_data_o,
    input  wire logic        rsp_ready_i
);

    glue_state_s q;
    glue_state_s d;
    logic        rise;
    logic [31:0] addr;

    always_comb begin
        d = q;
        rise = 1'b0;
        d.wr_done = 1'b0;
        // Three-stage synchronisers; a level counts once stages two and three agree
        d.clk_s  = {q.clk_s[1:0], shared_bus_clock_i};
        d.rdy_s  = {q.rdy_s[1:0], host_ready_n_i};
        d.hreq_s = {q.hreq_s[1:0], bus_hold_request_i};
        d.int_s  = {q.int_s[1:0], interrupt_in_i};
        if (q.clk_s[2] == q.clk_s[1]) d.clk_lvl = q.clk_s[2];
        if (q.rdy_s[2] == q.rdy_s[1]) d.rdy_lvl = q.rdy_s[2];
        if (q.hreq_s[2] == q.hreq_s[1]) d.hreq_lvl = q.hreq_s[2];
        if (q.int_s[2] == q.int_s[1]) d.int_lvl = q.int_s[2];
        rise = d.clk_lvl & ~q.clk_lvl;
        addr = q.c_ptr ? `ADDR_PTR_ADDR : `DATA_WIN_ADDR;

        // Response buffer drains regardless of bus activity
        if (rsp_ready_i && q.bcnt != 2'h0) begin
            d.buf0 = q.buf1;
            d.bcnt = q.bcnt - 2'h1;
        end

        if (q.st == ST_IDLE && q.cmd_ready && cmd_valid_i) begin
            d.pend    = 1'b1;
            d.c_write = cmd_write_i;
            d.c_ptr   = cmd_ptr_i;
            d.c_wdata = cmd_wdata_i;
            d.c_lanes = cmd_lanes_i;
        end

        case (q.st)
            ST_DEVRST: begin
                d.ad_oe = 1'b0;
                if (q.cnt == 8'(`DEV_RST_CYC)) begin
                    d.cnt       = 8'h0;
                    d.dev_rst_n = 1'b1;
                    // Hold goes up with the release so the host never sees a free bus
                    d.grant     = 1'b1;
                    d.st        = ST_DEVEXIT;
                end else begin
                    d.cnt = q.cnt + 8'h1;
                end
            end
            ST_DEVEXIT: begin
                // Bus stays floated while grant is up; the device latched its straps from the pulls during reset
                d.grant = 1'b1;
                d.ad_oe = 1'b0;
                if (q.cnt == 8'(`DEV_EXIT_CYC)) begin
                    d.grant = 1'b0;
                    d.st    = ST_LOAD;
                end else begin
                    d.cnt = q.cnt + 8'h1;
                end
            end
            ST_LOAD: begin
                // Attributes load one per cycle; valid bit sets with the last one so none is used half-built
                d.region_w[q.ridx*2 +: 2] = 2'(`REGION_TABLE >> (q.ridx * 2));
                d.ridx = q.ridx + 3'h1;
                if (q.ridx == 3'(`REGION_CNT - 1)) begin
                    d.tbl_valid = 1'b1;
                    d.data_cache_enable      = `DATA_CACHE_ENABLE_INIT;
                    d.byte_ord  = `BYTE_ORD_INIT;
                    d.st        = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (rise) begin
                    d.as_n  = 1'b1;
                    d.cs_n  = 1'b1;
                    d.ad_oe = 1'b0;
                    if (q.hreq_lvl) begin
                        d.grant = 1'b1;
                        d.st    = ST_HOLD;
                    end else if (q.pend && q.bcnt != `BUF_DEPTH
                                 && q.region_w[addr[`REGION_HI:`REGION_LO]*2 +: 2] == `BW_32) begin
                        d.ad      = addr;
                        d.ad_oe   = 1'b1;
                        d.as_n    = 1'b0;
                        d.cs_n    = 1'b0;
                        d.rsel    = addr[`SEL_BIT];
                        d.dir     = q.c_write ? `DIR_WRITE : ~`DIR_WRITE;
                        d.lanes   = q.c_lanes;
                        d.host_burst_last_n = 1'b0;
                        d.st      = ST_DATA;
                    end
                end
            end
            ST_DATA: begin
                if (rise) begin
                    d.as_n = 1'b1;
                    if (q.as_n) begin
                        if (!q.rdy_lvl) begin
                            d.cs_n    = 1'b1;
                            d.ad_oe   = 1'b0;
                            d.host_burst_last_n = 1'b1;
                            d.pend    = 1'b0;
                            d.st      = ST_IDLE;
                            if (q.c_write) begin
                                d.wr_done = 1'b1;
                            end else begin
                                if (d.bcnt == 2'h0) d.buf0 = shared_data_bus_i;
                                else d.buf1 = shared_data_bus_i;
                                d.bcnt = d.bcnt + 2'h1;
                            end
                        end
                    end else begin
                        d.ad    = q.c_wdata;
                        d.ad_oe = q.c_write;
                    end
                end
            end
            ST_HOLD: begin
                d.ad_oe = 1'b0;
                if (rise && !q.hreq_lvl) begin
                    d.grant = 1'b0;
                    d.st    = ST_IDLE;
                end
            end
            default: d.st = ST_DEVRST;
        endcase

        d.cmd_ready = (d.st == ST_IDLE) && !d.pend && d.tbl_valid;
        d.rsp_valid = d.bcnt != 2'h0;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q           <= '0;
            q.st        <= ST_DEVRST;
            q.as_n      <= 1'b1;
            q.cs_n      <= 1'b1;
            q.host_burst_last_n   <= 1'b1;
            q.rdy_s     <= 3'h7;
            q.rdy_lvl   <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign dev_reset_n_o        = q.dev_rst_n;
    assign shared_data_bus_o    = q.ad;
    assign shared_data_bus_oe_o = q.ad_oe;
    assign host_addr_strobe_n_o = q.as_n;
    assign device_select_n_o    = q.cs_n;
    assign register_select_o    = q.rsel;
    assign direction_o          = q.dir;
    assign host_burst_last_n_o  = q.host_burst_last_n;
    assign host_lane_enables_o  = q.lanes;
    assign bus_hold_grant_o     = q.grant;
    assign irq_o                = q.int_lvl;
    assign cmd_ready_o          = q.cmd_ready;
    assign wr_done_o            = q.wr_done;
    assign rsp_valid_o          = q.rsp_valid;
    assign rsp_data_o           = q.buf0;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    bus_float_rst_a: assert property ((q.st == ST_DEVRST) |-> !q.ad_oe && !q.dev_rst_n)
        else $error("bus driven during device reset");
    dev_release_a: assert property ($rose(q.dev_rst_n) |-> q.grant ##1 q.grant)
        else $error("device released without hold");
    select_bit_a: assert property (!q.as_n |-> q.rsel == q.ad[`SEL_BIT] && !q.cs_n)
        else $error("register select mismatch");
    decode_addr_a: assert property ($fell(q.cs_n) |-> q.ad == `DATA_WIN_ADDR
                                    || q.ad == `ADDR_PTR_ADDR)
        else $error("chip select on foreign address");
    strobe_step_a: assert property ($changed(q.as_n) |-> $past(rise))
        else $error("strobe moved off link edge");
    host_burst_last_beat_a: assert property ((q.st == ST_DATA) |-> !q.host_burst_last_n && !q.cs_n)
        else $error("burst-last missing in data beat");
    width_cfg_a: assert property ($fell(q.as_n) |-> q.tbl_valid && q.region_w[1:0] == `BW_32)
        else $error("access before region configured");
    logic_cfg_a: assert property ($rose(q.tbl_valid) |-> !q.data_cache_enable && !q.byte_ord
                                  && q.st == ST_IDLE)
        else $error("logical configuration wrong");
    hold_float_a: assert property ((q.st == ST_HOLD) |-> q.grant && !q.ad_oe)
        else $error("bus driven while held");

    write_cov_c: cover property (!q.as_n && q.dir == `DIR_WRITE ##[1:40] q.wr_done);
    read_cov_c: cover property (!q.as_n && q.dir != `DIR_WRITE ##[1:40] $rose(q.rsp_valid));
    hold_cov_c: cover property ($rose(q.grant) && q.st == ST_HOLD);
    full_cov_c: cover property (q.bcnt == `BUF_DEPTH);

endmodule // host_glue

`default_nettype wire

// File: host_glue_params.svh
`ifndef HOST_GLUE_PARAMS_SVH
`define HOST_GLUE_PARAMS_SVH

`define CLK_MHZ        10
`define DEV_RST_NS     2000
`define DEV_EXIT_NS    4000
`define DEV_RST_CYC    ((`DEV_RST_NS * `CLK_MHZ + 999) / 1000)
`define DEV_EXIT_CYC   ((`DEV_EXIT_NS * `CLK_MHZ + 999) / 1000)
`define DATA_WIN_ADDR  32'h1000_0000
`define ADDR_PTR_ADDR  32'h1000_0004
`define SEL_BIT        2
`define REGION_HI      31
`define REGION_LO      29
`define REGION_CNT     8
`define BW_32          2'h2
`define REGION_TABLE   16'h0002
`define DATA_CACHE_ENABLE_INIT      1'h0
`define BYTE_ORD_INIT  1'h0
`define DIR_WRITE      1'h1
`define BUF_DEPTH      2'h2

`endif

// File: host_glue_pkg.sv
package host_glue_pkg;

    typedef enum logic [5:0] {
        ST_DEVRST  = 6'h01,
        ST_DEVEXIT = 6'h02,
        ST_LOAD    = 6'h04,
        ST_IDLE    = 6'h08,
        ST_DATA    = 6'h10,
        ST_HOLD    = 6'h20
    } glue_state_e;

    typedef struct packed {
        glue_state_e  st;
        logic [7:0]   cnt;
        logic [2:0]   ridx;
        logic [15:0]  region_w;
        logic         tbl_valid;
        logic         data_cache_enable;
        logic         byte_ord;
        logic [2:0]   clk_s;
        logic [2:0]   rdy_s;
        logic [2:0]   hreq_s;
        logic [2:0]   int_s;
        logic         clk_lvl;
        logic         rdy_lvl;
        logic         hreq_lvl;
        logic         int_lvl;
        logic         pend;
        logic         c_write;
        logic         c_ptr;
        logic [31:0]  c_wdata;
        logic [3:0]   c_lanes;
        logic         cmd_ready;
        logic         dev_rst_n;
        logic [31:0]  ad;
        logic         ad_oe;
        logic         as_n;
        logic         cs_n;
        logic         rsel;
        logic         dir;
        logic         host_burst_last_n;
        logic [3:0]   lanes;
        logic         grant;
        logic         wr_done;
        logic [1:0]   bcnt;
        logic [31:0]  buf0;
        logic [31:0]  buf1;
        logic         rsp_valid;
    } glue_state_s;

endpackage

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [31:0] PULLS = 32'h0000_c0a5;
    logic clk = 0, rst_n = 0, lclk = 0, intr = 0, want = 0;
    logic cmd_valid = 0, cmd_write = 0, cmd_ptr = 0, rsp_ready = 0;
    logic [31:0] cmd_wdata = '0;
    logic [3:0] cmd_lanes = '0;
    logic [2:0] wait_c = '0;
    logic dev_rst_n, hoe, as_n, cs_n, rsel, dir, bl_n, rdy_n, hold, grant;
    logic irq, cmd_ready, wr_done, rsp_valid, doe;
    logic [31:0] hdo, ddo, rsp_data, cfg;
    logic [3:0] lanes;
    int miscompares = 0, compares = 0, faults;
    wire logic [31:0] bus = hoe ? hdo : doe ? ddo : PULLS;
    always #50 clk = ~clk;
    always #400 lclk = ~lclk;
    host_glue dut_u (
        .clk_i(clk), .rst_n_i(rst_n), .shared_bus_clock_i(lclk), .dev_reset_n_o(dev_rst_n),
        .shared_data_bus_i(bus), .shared_data_bus_o(hdo), .shared_data_bus_oe_o(hoe),
        .host_addr_strobe_n_o(as_n), .device_select_n_o(cs_n), .register_select_o(rsel),
        .direction_o(dir), .host_burst_last_n_o(bl_n), .host_lane_enables_o(lanes),
        .host_ready_n_i(rdy_n), .bus_hold_request_i(hold), .bus_hold_grant_o(grant),
        .interrupt_in_i(intr), .irq_o(irq), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
        .cmd_write_i(cmd_write), .cmd_ptr_i(cmd_ptr), .cmd_wdata_i(cmd_wdata),
        .cmd_lanes_i(cmd_lanes), .wr_done_o(wr_done), .rsp_valid_o(rsp_valid),
        .rsp_data_o(rsp_data), .rsp_ready_i(rsp_ready));
    dev_model dev_u (
        .lclk_i(lclk), .rst_n_i(dev_rst_n), .bus_i(bus), .hoe_i(hoe), .as_n_i(as_n),
        .cs_n_i(cs_n), .rsel_i(rsel), .dir_i(dir), .bl_n_i(bl_n), .ln_i(lanes),
        .gnt_i(grant), .wait_i(wait_c), .want_i(want), .rdy_n_o(rdy_n), .do_o(ddo),
        .oe_o(doe), .hold_o(hold), .cfg_o(cfg), .faults_o(faults));
    task automatic results();
        if (miscompares == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic await_lvl(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 4000) begin
            @(negedge clk);
            n++;
        end
        check("wait level", {31'h0, s}, {31'h0, v});
    endtask
    task automatic issue(input logic w, p, input logic [31:0] d, input logic [3:0] l);
        @(negedge clk);
        await_lvl(cmd_ready, 1);
        cmd_valid = 1;
        cmd_write = w;
        cmd_ptr = p;
        cmd_wdata = d;
        cmd_lanes = l;
        @(negedge clk);
        cmd_valid = 0;
    endtask
    task automatic wr(input logic p, input logic [31:0] d, input logic [3:0] l);
        issue(1, p, d, l);
        await_lvl(wr_done, 1);
    endtask
    task automatic pop(input logic [31:0] e);
        await_lvl(rsp_valid, 1);
        check("read data", rsp_data, e);
        rsp_ready = 1;
        @(negedge clk);
        rsp_ready = 0;
    endtask
    initial begin
        repeat (10) @(negedge clk);
        check("device reset", {31'h0, dev_rst_n}, 0);
        rst_n = 1;
        await_lvl(dev_rst_n, 1);
        check("grant at device exit", {31'h0, grant}, 1);
        await_lvl(cmd_ready, 1);
        check("config word", cfg, PULLS);
        wr(1, 32'h0000_0040, 4'hf);
        wr(0, 32'h1234_5678, 4'hf);
        issue(0, 1, '0, 4'hf);
        pop(32'h0000_0040);
        wr(0, 32'haabb_ccdd, 4'h5);
        issue(0, 0, '0, 4'hf);
        pop(32'h12bb_56dd);
        // Slow device and a stalled reader: both reads must sit in the buffer
        wait_c = 3'h5;
        wr(0, 32'h0000_0000, 4'ha);
        issue(0, 0, '0, 4'hf);
        issue(0, 1, '0, 4'hf);
        await_lvl(cmd_ready, 1);
        pop(32'h00bb_00dd);
        pop(32'h0000_0040);
        want = 1;
        await_lvl(grant, 1);
        repeat (20) @(negedge clk);
        check("ready while held", {31'h0, cmd_ready}, 0);
        want = 0;
        await_lvl(grant, 0);
        intr = 1;
        repeat (8) @(negedge clk);
        check("interrupt", {31'h0, irq}, 1);
        intr = 0;
        repeat (8) @(negedge clk);
        check("interrupt", {31'h0, irq}, 0);
        check("device faults", faults, 0);
        results();
    end
    initial begin
        #400_000;
        miscompares++;
        results();
    end
endmodule // tb_top
`default_nettype wire
